// ==== sim/dmacfg_far_model.sv ====
// Far-side model: request lines and byte-done strobes
`timescale 1ns/1ps
`default_nettype none
module dmacfg_far_model (
    // Clock
    input wire logic aclk,
    // Request and strobe lines
    output logic req0_n,
    output logic req1_n,
    output logic ser0,
    output logic ser1,
    output logic step0,
    output logic step1
);
    // Pins idle high, strobes low
    initial {req0_n, req1_n, step0, step1} = 4'hC;
    int sel = 3;
    // Serial peripherals raise their request one edge after being picked
    always @(posedge aclk) begin
        ser0 <= sel == 1;
        ser1 <= sel == 2;
    end
    task automatic src(input int k);
        @(posedge aclk);
        req0_n <= k != 0;
        req1_n <= k != 0;
        sel <= k;
    endtask
    task automatic pulse(input logic [1:0] c);
        @(posedge aclk);
        {step1, step0} <= c;
        @(posedge aclk);
        {step1, step0} <= 2'h0;
    endtask
endmodule
`default_nettype wire

// ==== sim/dmacfg_test.sv ====
// Self-checking bench for the transfer setup block
`timescale 1ns/1ps
`default_nettype none
module dmacfg_test import dmacfg_pkg::*; ();
    logic aclk = 1'b0, aresetn = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0;
    logic r_r = 1'b0, aw_r, w_r, b_v, ar_r, r_v, p0, p1, s0, s1, t0, t1, q0, q1, sio, dio;
    logic bst, c1d;
    logic [ADDR_W-1:0] awa = 10'h000, ara = 10'h000;
    logic [31:0] rdat, wd = 32'h0;
    logic [3:0] ws = 4'hF;
    logic [1:0] b_s, r_s, mw;
    logic [2:0] iw;
    logic [2:0] iwt [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
    logic [19:0] sa, da, ma, e;
    logic [15:0] ia;
    int err_total = 0, total_checks = 0, n;
    dmacfg_top i_dmacfg_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ara), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(rdat), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .ext_request_ch0_n(p0), .ext_request_ch1_n(p1), .serial0_rx_request(s0),
        .serial1_tx_request(s1), .ch0_step(t0), .ch1_step(t1), .ch0_source_address(sa),
        .ch0_dest_address(da), .ch1_memory_address(ma), .ch1_io_address(ia),
        .ch0_src_is_io(sio), .ch0_dst_is_io(dio), .ch0_burst(bst), .ch1_io_to_mem(c1d),
        .memory_wait_count(mw), .io_wait_count(iw), .ch0_request(q0), .ch1_request(q1));
    dmacfg_far_model i_dmacfg_far_model (.aclk(aclk), .req0_n(p0), .req1_n(p1), .ser0(s0),
        .ser1(s1), .step0(t0), .step1(t1));
    always #12.5 aclk = ~aclk;
    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awa <= {i, 2'h0};
        wd <= {24'h0, d};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_r) aw_v <= 1'b0;
            if (w_r) w_v <= 1'b0;
        end while ((aw_v && !aw_r) || (w_v && !w_r));
        do @(posedge aclk); while (!b_v);
        b_r <= 1'b0;
        chk("bresp", b_s, er);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] x, input logic [1:0] er);
        @(posedge aclk);
        ara <= {i, 2'h0};
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do @(posedge aclk); while (!ar_r);
        ar_v <= 1'b0;
        do @(posedge aclk); while (!r_v);
        r_r <= 1'b0;
        chk("rdata", rdat, x);
        chk("rresp", r_s, er);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wr(IDX_DST_EXT, 8'hFF, RESP_OKAY);
        rd(IDX_DST_EXT, 32'h0F, RESP_OKAY);
        wr(8'h30, 8'h55, RESP_SLVERR);
        rd(8'h30, 32'h0, RESP_SLVERR);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_MODE, 8'(m * 20), RESP_OKAY);
            for (int k = 0; k < 6; k++) begin
                wr(IDX_SRC_LOW + 8'(k), {8{k % 3 != 2}}, RESP_OKAY);
            end
            i_dmacfg_far_model.pulse(2'h1);
            cyc(2);
            e = m == 0 ? 20'h10000 : m == 1 ? 20'h0FFFE : 20'h0FFFF;
            chk("src", sa, e);
            chk("dst", da, e);
            chk("io", {sio, dio}, {2{m == 3}});
            rd(IDX_SRC_EXT, {28'h0, e[19:16]}, RESP_OKAY);
        end
        for (int c = 0; c < 4; c++) begin
            wr(IDX_WAIT, 8'(c * 81), RESP_OKAY);
            chk("mwait", mw, c);
            chk("iwait", iw, iwt[c]);
            chk("c1dir", c1d, c >> 1);
            for (int k = 0; k < 3; k++) begin
                wr(IDX_CH1_MEM_LOW + 8'(k), {8{k != 2}}, RESP_OKAY);
            end
            i_dmacfg_far_model.pulse(2'h2);
            cyc(2);
            chk("mar", ma, c % 2 ? 20'h0FFFE : 20'h10000);
        end
        wr(IDX_CH1_IO_LOW, 8'h5A, RESP_OKAY);
        wr(IDX_CH1_IO_HIGH, 8'hC3, RESP_OKAY);
        // Lane 0 strobe off: answered but nothing stored
        ws <= 4'h0;
        wr(IDX_CH1_IO_LOW, 8'h00, RESP_OKAY);
        ws <= 4'hF;
        chk("iar", ia, 16'hC35A);
        wr(IDX_MODE, 8'h0C, RESP_OKAY);
        wr(IDX_WAIT, 8'h00, RESP_OKAY);
        for (int s = 0; s < 4; s++) begin
            wr(IDX_SRC_EXT, 8'(s), RESP_OKAY);
            for (int k = 0; k < 4; k++) begin
                i_dmacfg_far_model.src(k);
                cyc(8);
                chk("req", {q1, q0}, {k == 0, s == k && k < 3});
            end
        end
        wr(IDX_SRC_EXT, 8'h00, RESP_OKAY);
        wr(IDX_WAIT, 8'h0C, RESP_OKAY);
        i_dmacfg_far_model.src(0);
        cyc(2);
        i_dmacfg_far_model.src(3);
        cyc(8);
        chk("edge", {q1, q0}, 2'h3);
        i_dmacfg_far_model.pulse(2'h3);
        cyc(4);
        chk("used", {q1, q0}, 2'h0);
        // Source on memory: the request source comes from the dest ext byte
        wr(IDX_MODE, 8'h30, RESP_OKAY);
        wr(IDX_DST_EXT, 8'h01, RESP_OKAY);
        i_dmacfg_far_model.src(1);
        cyc(8);
        chk("dsel", q0, 1'b1);
        for (int b = 0; b < 2; b++) begin
            wr(IDX_MODE, 8'(b * 2), RESP_OKAY);
            chk("burst", bst, b);
            i_dmacfg_far_model.pulse(2'h1);
            n = 0;
            repeat (4) begin
                @(posedge aclk);
                n += !q0;
            end
            chk("steal", n, 1 - b);
        end
        tally_and_finish();
    end
    // Generous margin over the several hundred cycles the tests need
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== src/dmacfg_pkg.sv ====
// Package: constants, types and helpers of the two-channel transfer setup block
// Functional notes
// - Channel 0 source address lives in three byte registers at indices 20h, 21h, 22h.
// - Channel 0 destination address lives in byte registers at indices 23h, 24h, 25h.
// - Destination mode: 00 memory inc, 01 memory dec, 10 memory fixed, 11 I/O fixed.
// - Source mode: 00 memory inc, 01 memory dec, 10 memory fixed, 11 I/O fixed.
// - For an I/O side, ext address bits 17:16 pick pin, serial 0 rx, serial 1 tx, none.
// - Memory-to-memory runs cycle-steal with burst_select at 0 and burst with it at 1.
// - Memory wait count inserts as many wait states as its binary value.
// - I/O wait count adds 0 for code 00, 3 for code 10 and 4 for code 11.
// - Each request sense bit makes its external request edge sensed at 1, level at 0.
// - Channel 1 mode: 00/01 memory to I/O inc/dec, 10/11 I/O to memory inc/dec.
package dmacfg_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_SRC_LOW = 8'h20;
    localparam logic [7:0] IDX_SRC_HIGH = 8'h21;
    localparam logic [7:0] IDX_SRC_EXT = 8'h22;
    localparam logic [7:0] IDX_DST_LOW = 8'h23;
    localparam logic [7:0] IDX_DST_HIGH = 8'h24;
    localparam logic [7:0] IDX_DST_EXT = 8'h25;
    localparam logic [7:0] IDX_CH1_MEM_LOW = 8'h40;
    localparam logic [7:0] IDX_CH1_MEM_HIGH = 8'h41;
    localparam logic [7:0] IDX_CH1_MEM_EXT = 8'h42;
    localparam logic [7:0] IDX_CH1_IO_LOW = 8'h43;
    localparam logic [7:0] IDX_CH1_IO_HIGH = 8'h44;
    localparam logic [7:0] IDX_MODE = 8'h48;
    localparam logic [7:0] IDX_WAIT = 8'h49;
    localparam logic [7:0] IDX_STATUS = 8'h4A;

    // ==========================================================
    // Field positions
    localparam int MODE_DST_LSB = 4;
    localparam int MODE_SRC_LSB = 2;
    localparam int MODE_BURST_BIT = 1;
    localparam int WAIT_MEM_LSB = 6;
    localparam int WAIT_IO_LSB = 4;
    localparam int WAIT_SENSE1_BIT = 3;
    localparam int WAIT_SENSE0_BIT = 2;
    localparam int WAIT_CH1_LSB = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] WAIT_RST = 8'h00;
    localparam logic [19:0] ADDR_RST = 20'h00000;
    localparam logic [15:0] IO_ADDR_RST = 16'h0000;

    // ==========================================================
    // Encodings
    typedef enum logic [1:0] {
        AMODE_INC = 2'h0,
        AMODE_DEC = 2'h1,
        AMODE_FIX = 2'h2,
        AMODE_IO = 2'h3
    } dmacfg_amode_t;

    typedef enum logic [1:0] {
        RSRC_PIN = 2'h0,
        RSRC_SER0 = 2'h1,
        RSRC_SER1 = 2'h2,
        RSRC_NONE = 2'h3
    } dmacfg_rsrc_t;

    localparam logic [2:0] IO_WAIT_C0 = 3'h0;
    localparam logic [2:0] IO_WAIT_C1 = 3'h2;
    localparam logic [2:0] IO_WAIT_C2 = 3'h3;
    localparam logic [2:0] IO_WAIT_C3 = 3'h4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Helpers
    function automatic logic [19:0] addr_step(input logic [19:0] a, input logic [1:0] m);
        logic [19:0] r;
        r = a;
        if (m == AMODE_INC) begin
            r = a + 20'h00001;
        end else if (m == AMODE_DEC) begin
            r = a - 20'h00001;
        end
        return r;
    endfunction

    function automatic logic [2:0] io_wait_decode(input logic [1:0] c);
        logic [2:0] r;
        unique case (c)
            2'h0: r = IO_WAIT_C0;
            2'h1: r = IO_WAIT_C1;
            2'h2: r = IO_WAIT_C2;
            2'h3: r = IO_WAIT_C3;
        endcase
        return r;
    endfunction

endpackage

// ==== src/dmacfg_req_cond.sv ====
// Request sense unit: pin synchronisers and edge or level request capture
`timescale 1ns/1ps
`default_nettype none
module dmacfg_req_cond (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Core side
    dmacfg_req_if.cond rq
);
    logic [1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, pend_q, pend_d;

    // ==========================================================
    // Next state
    always_comb begin
        s1_d = rq.pin_n;
        s2_d = s1_q;
        s3_d = s2_q;
        for (int i = 0; i < 2; i++) begin
            if (rq.sense[i]) begin
                // New edge wins over a consume in the same cycle
                pend_d[i] = (pend_q[i] & ~rq.consume[i]) | (s3_q[i] & ~s2_q[i]);
            end else begin
                pend_d[i] = ~s2_q[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
            s3_q <= 2'h3;
            pend_q <= 2'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            pend_q <= pend_d;
        end
    end

    assign rq.pending = pend_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_fall0;
        (rq.sense[0] && rq.pin_n[0]) ##1 (rq.sense[0] && !rq.pin_n[0]) [*3];
    endsequence

    sequence s_low0;
        (!rq.sense[0] && !rq.pin_n[0]) [*3];
    endsequence

    AST_EDGE_CAPTURE: assert property (s_fall0 |=> rq.pending[0])
        else $error("edge on request pin 0 not captured");
    AST_LEVEL_FOLLOW: assert property (s_low0 |=> rq.pending[0])
        else $error("low level on request pin 0 not seen");
    AST_EDGE_HOLD: assert property (rq.sense[1] && rq.pending[1] && !rq.consume[1]
        |=> rq.pending[1])
        else $error("edge request 1 lost without consume");
    AST_LEVEL_DROP: assert property ((!rq.sense[1] && rq.pin_n[1]) [*3]
        |=> !rq.pending[1])
        else $error("level request 1 stays with pin idle");

endmodule
`default_nettype wire

// ==== src/dmacfg_req_if.sv ====
// Interface: request conditioning signals between the setup core and the sense unit
`timescale 1ns/1ps
`default_nettype none
interface dmacfg_req_if;
    logic [1:0] pin_n;
    logic [1:0] sense;
    logic [1:0] consume;
    logic [1:0] pending;

    modport cond (input pin_n, input sense, input consume, output pending);
    modport core (output pin_n, output sense, output consume, input pending);
endinterface
`default_nettype wire

// ==== src/dmacfg_top.sv ====
// Two-channel transfer setup: register file, address stepping and request select
`timescale 1ns/1ps
`default_nettype none
module dmacfg_top import dmacfg_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Request sources
    input wire logic ext_request_ch0_n,
    input wire logic ext_request_ch1_n,
    input wire logic serial0_rx_request,
    input wire logic serial1_tx_request,
    // Byte transfer done strobes
    input wire logic ch0_step,
    input wire logic ch1_step,
    // Transfer setup
    output logic [19:0] ch0_source_address,
    output logic [19:0] ch0_dest_address,
    output logic [19:0] ch1_memory_address,
    output logic [15:0] ch1_io_address,
    output logic ch0_src_is_io,
    output logic ch0_dst_is_io,
    output logic ch0_burst,
    output logic ch1_io_to_mem,
    output logic [1:0] memory_wait_count,
    output logic [2:0] io_wait_count,
    output logic ch0_request,
    output logic ch1_request
);

    // ==========================================================
    // Request sense unit
    dmacfg_req_if rq ();

    dmacfg_req_cond u_cond (
        .aclk(aclk),
        .aresetn(aresetn),
        .rq(rq)
    );

    // ==========================================================
    // AXI4-Lite write path
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic do_write, wr_en;
    logic [7:0] aw_idx;

    assign do_write = aw_have_q && w_have_q;
    assign wr_en = do_write && wstrb0_q;
    assign aw_idx = awaddr_q[ADDR_W-1:2];

    function automatic logic idx_mapped(input logic [7:0] idx);
        return (idx >= IDX_SRC_LOW && idx <= IDX_DST_EXT)
            || (idx >= IDX_CH1_MEM_LOW && idx <= IDX_CH1_IO_HIGH)
            || (idx >= IDX_MODE && idx <= IDX_STATUS);
    endfunction

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb0_d = s_axi_wstrb[0];
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = idx_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        // One write in flight: hold off until the response is taken
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
        end
    end

    // ==========================================================
    // Configuration registers and address stepping
    logic [19:0] src_q, src_d, dst_q, dst_d, m1_q, m1_d;
    logic [15:0] io1_q, io1_d;
    logic [7:0] mode_q, mode_d, wctl_q, wctl_d;
    logic [1:0] src_mode, dst_mode, ch1_mode;

    assign src_mode = mode_q[MODE_SRC_LSB +: 2];
    assign dst_mode = mode_q[MODE_DST_LSB +: 2];
    assign ch1_mode = wctl_q[WAIT_CH1_LSB +: 2];

    always_comb begin
        src_d = src_q;
        dst_d = dst_q;
        m1_d = m1_q;
        io1_d = io1_q;
        mode_d = mode_q;
        wctl_d = wctl_q;
        // Whole 20-bit step, so carries cross into the ext byte
        if (ch0_step) begin
            src_d = addr_step(src_q, src_mode);
            dst_d = addr_step(dst_q, dst_mode);
        end
        if (ch1_step) begin
            m1_d = addr_step(m1_q, {1'b0, ch1_mode[0]});
        end
        // A software write lands on top of a step in the same cycle
        if (wr_en) begin
            unique case (aw_idx)
                IDX_SRC_LOW: src_d[7:0] = wdata_q[7:0];
                IDX_SRC_HIGH: src_d[15:8] = wdata_q[7:0];
                IDX_SRC_EXT: src_d[19:16] = wdata_q[3:0];
                IDX_DST_LOW: dst_d[7:0] = wdata_q[7:0];
                IDX_DST_HIGH: dst_d[15:8] = wdata_q[7:0];
                IDX_DST_EXT: dst_d[19:16] = wdata_q[3:0];
                IDX_CH1_MEM_LOW: m1_d[7:0] = wdata_q[7:0];
                IDX_CH1_MEM_HIGH: m1_d[15:8] = wdata_q[7:0];
                IDX_CH1_MEM_EXT: m1_d[19:16] = wdata_q[3:0];
                IDX_CH1_IO_LOW: io1_d[7:0] = wdata_q[7:0];
                IDX_CH1_IO_HIGH: io1_d[15:8] = wdata_q[7:0];
                IDX_MODE: mode_d = wdata_q[7:0];
                IDX_WAIT: wctl_d = wdata_q[7:0];
                default: ;
            endcase
        end
    end

    // Decoded setup, registered from next values so it tracks the fields
    logic src_io_d, dst_io_d, burst_d, dir_d;
    logic [1:0] mwait_d;
    logic [2:0] iwait_d;

    always_comb begin
        src_io_d = mode_d[MODE_SRC_LSB +: 2] == AMODE_IO;
        dst_io_d = mode_d[MODE_DST_LSB +: 2] == AMODE_IO;
        burst_d = mode_d[MODE_BURST_BIT];
        dir_d = wctl_d[WAIT_CH1_LSB + 1];
        mwait_d = wctl_d[WAIT_MEM_LSB +: 2];
        iwait_d = io_wait_decode(wctl_d[WAIT_IO_LSB +: 2]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_q <= ADDR_RST;
            dst_q <= ADDR_RST;
            m1_q <= ADDR_RST;
            io1_q <= IO_ADDR_RST;
            mode_q <= MODE_RST;
            wctl_q <= WAIT_RST;
            ch0_src_is_io <= 1'b0;
            ch0_dst_is_io <= 1'b0;
            ch0_burst <= 1'b0;
            ch1_io_to_mem <= 1'b0;
            memory_wait_count <= 2'h0;
            io_wait_count <= IO_WAIT_C0;
        end else begin
            src_q <= src_d;
            dst_q <= dst_d;
            m1_q <= m1_d;
            io1_q <= io1_d;
            mode_q <= mode_d;
            wctl_q <= wctl_d;
            ch0_src_is_io <= src_io_d;
            ch0_dst_is_io <= dst_io_d;
            ch0_burst <= burst_d;
            ch1_io_to_mem <= dir_d;
            memory_wait_count <= mwait_d;
            io_wait_count <= iwait_d;
        end
    end

    assign ch0_source_address = src_q;
    assign ch0_dest_address = dst_q;
    assign ch1_memory_address = m1_q;
    assign ch1_io_address = io1_q;

    // ==========================================================
    // Request selection
    logic mem_to_mem, req0_q, req0_d, req1_q, req1_d;
    logic [1:0] rsel;

    assign mem_to_mem = (src_mode != AMODE_IO) && (dst_mode != AMODE_IO);
    // Source side I/O takes precedence when both sides are I/O
    assign rsel = (src_mode == AMODE_IO) ? src_q[17:16] : dst_q[17:16];

    assign rq.pin_n = {ext_request_ch1_n, ext_request_ch0_n};
    assign rq.sense = {wctl_q[WAIT_SENSE1_BIT], wctl_q[WAIT_SENSE0_BIT]};
    assign rq.consume = {ch1_step, ch0_step && !mem_to_mem && rsel == RSRC_PIN};

    always_comb begin
        if (mem_to_mem) begin
            // Cycle steal gives one bus cycle back after every byte
            req0_d = mode_q[MODE_BURST_BIT] || !ch0_step;
        end else begin
            unique case (rsel)
                RSRC_PIN: req0_d = rq.pending[0];
                RSRC_SER0: req0_d = serial0_rx_request;
                RSRC_SER1: req0_d = serial1_tx_request;
                RSRC_NONE: req0_d = 1'b0;
            endcase
        end
        req1_d = rq.pending[1];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req0_q <= 1'b0;
            req1_q <= 1'b0;
        end else begin
            req0_q <= req0_d;
            req1_q <= req1_d;
        end
    end

    assign ch0_request = req0_q;
    assign ch1_request = req1_q;

    // ==========================================================
    // AXI4-Lite read path
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [7:0] ar_idx, rd_byte;

    assign ar_idx = s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        unique case (ar_idx)
            IDX_SRC_LOW: rd_byte = src_q[7:0];
            IDX_SRC_HIGH: rd_byte = src_q[15:8];
            IDX_SRC_EXT: rd_byte = {4'h0, src_q[19:16]};
            IDX_DST_LOW: rd_byte = dst_q[7:0];
            IDX_DST_HIGH: rd_byte = dst_q[15:8];
            IDX_DST_EXT: rd_byte = {4'h0, dst_q[19:16]};
            IDX_CH1_MEM_LOW: rd_byte = m1_q[7:0];
            IDX_CH1_MEM_HIGH: rd_byte = m1_q[15:8];
            IDX_CH1_MEM_EXT: rd_byte = {4'h0, m1_q[19:16]};
            IDX_CH1_IO_LOW: rd_byte = io1_q[7:0];
            IDX_CH1_IO_HIGH: rd_byte = io1_q[15:8];
            IDX_MODE: rd_byte = mode_q;
            IDX_WAIT: rd_byte = wctl_q;
            IDX_STATUS: rd_byte = {4'h0, rq.pending, req1_q, req0_q};
            default: rd_byte = 8'h00;
        endcase
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = {24'h000000, rd_byte};
            rresp_d = idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ch0_step_clean;
        ch0_step && !wr_en;
    endsequence

    sequence s_steal;
        mem_to_mem && !mode_q[MODE_BURST_BIT] && ch0_step;
    endsequence

    AST_SRC_EXT_WRITE: assert property (wr_en && aw_idx == IDX_SRC_EXT
        |=> src_q[19:16] == $past(wdata_q[3:0]) && ch0_source_address == src_q)
        else $error("source ext byte not written");
    AST_DST_LOW_WRITE: assert property (wr_en && aw_idx == IDX_DST_LOW
        |=> dst_q[7:0] == $past(wdata_q[7:0]))
        else $error("dest low byte not written");
    AST_DST_DEC: assert property (s_ch0_step_clean ##0 dst_mode == AMODE_DEC
        |=> dst_q == 20'($past(dst_q) - 20'h00001))
        else $error("dest address did not decrement");
    AST_SRC_INC: assert property (s_ch0_step_clean ##0 src_mode == AMODE_INC
        |=> src_q == 20'($past(src_q) + 20'h00001))
        else $error("source address did not increment");
    AST_SRC_FIXED: assert property (s_ch0_step_clean ##0 src_mode[1]
        |=> $stable(src_q))
        else $error("fixed source address moved");
    AST_CARRY: assert property (s_ch0_step_clean ##0 src_mode == AMODE_INC
        && src_q[15:0] == 16'hFFFF |=> src_q[15:0] == 16'h0000
        && src_q[19:16] == 4'($past(src_q[19:16]) + 4'h1))
        else $error("carry did not reach ext byte");
    AST_REQ_SER0: assert property (src_mode == AMODE_IO && src_q[17:16] == RSRC_SER0
        |=> ch0_request == $past(serial0_rx_request))
        else $error("serial 0 request not routed");
    AST_REQ_NONE: assert property (src_mode == AMODE_IO && src_q[17:16] == RSRC_NONE
        |=> !ch0_request)
        else $error("unused request code raised request");
    // Request is low in the cycle right after the step, back the cycle after
    AST_STEAL_GAP: assert property (s_steal ##1 (!ch0_step && mem_to_mem)
        |-> !ch0_request ##1 ch0_request)
        else $error("cycle steal gap missing");
    AST_BURST_HOLD: assert property (mem_to_mem && mode_q[MODE_BURST_BIT]
        |=> ch0_request)
        else $error("burst request dropped");
    AST_MEM_WAIT: assert property (wctl_q[WAIT_MEM_LSB +: 2] == 2'h3
        |-> memory_wait_count == 2'h3)
        else $error("memory wait count wrong");
    AST_IO_WAIT: assert property (wctl_q[WAIT_IO_LSB +: 2] == 2'h3
        |-> io_wait_count == 3'h4)
        else $error("I/O wait count wrong");
    AST_CH1_DEC: assert property (ch1_step && !wr_en && ch1_mode == 2'h3
        |=> m1_q == 20'($past(m1_q) - 20'h00001) && ch1_io_to_mem && $stable(io1_q))
        else $error("channel 1 memory address did not decrement");

endmodule
`default_nettype wire
